// >>> pkg/eeap_pkg.sv
// constants, types and decode helpers for the eeprom autosize/protect block
// assumes a microwire-like word-wide serial eeprom on the far side
package eeap_pkg;

  typedef enum logic [1:0] {
    SZ_NONE = 2'h0,
    SZ_4K   = 2'h1,
    SZ_8K   = 2'h2,
    SZ_16K  = 2'h3
  } eeap_size_t;

  localparam int unsigned AW      = 10;
  localparam int unsigned DW      = 16;
  localparam int unsigned FRAME_W = 29;
  localparam int unsigned CNT_W   = 5;
  localparam int unsigned MEM_AW  = 6;

  localparam logic [AW-1:0]     SIG_ADDR   = 10'h03d;
  localparam logic [DW-1:0]     SIG_VALUE  = 16'h5aa5;
  localparam logic [AW-1:0]     MASK_ADDR  = 10'h03f;
  localparam logic [MEM_AW-1:0] LOAD_LAST  = 6'h3f;
  localparam logic [DW-1:0]     MASK_DEFLT = 16'h0000;
  localparam logic [DW-1:0]     CFG_DEFLT  = 16'h0000;

  localparam logic       START_BIT = 1'b1;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [3:0] HEAD_W    = 4'h3;
  localparam logic [3:0] ABITS_4K  = 4'h8;
  localparam logic [3:0] ABITS_8K  = 4'h9;
  localparam logic [3:0] ABITS_16K = 4'ha;

  localparam logic [1:0] BOOT_WAIT   = 2'h3;
  localparam logic [6:0] SRST_CYCLES = 7'h40;

  // apb byte offsets
  localparam logic [11:0] OFF_ADDR   = 12'h000;
  localparam logic [11:0] OFF_DATA   = 12'h004;
  localparam logic [11:0] OFF_CMD    = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;
  localparam logic [11:0] OFF_MASK   = 12'h010;
  localparam logic [11:0] OFF_CTRL   = 12'h014;
  localparam logic [3:0]  CFG_PAGE   = 4'h1;

  localparam int unsigned CMD_RD    = 0;
  localparam int unsigned CMD_WR    = 1;
  localparam int unsigned CTRL_SRST = 0;
  localparam int unsigned FL_RD_DONE = 0;
  localparam int unsigned FL_RD_ERR  = 1;
  localparam int unsigned FL_WR_DONE = 2;
  localparam int unsigned FL_WR_ERR  = 3;
  localparam int unsigned SUB_NO_RD  = 0;
  localparam int unsigned SUB_NO_WR  = 1;
  localparam int unsigned SUB4K_LSB  = 4;

  localparam logic [AW-1:0] BND_32   = 10'h020;
  localparam logic [AW-1:0] BND_64   = 10'h040;
  localparam logic [AW-1:0] BND_128  = 10'h080;
  localparam logic [AW-1:0] BND_192  = 10'h0c0;
  localparam logic [AW-1:0] BND_256  = 10'h100;
  localparam logic [AW-1:0] BND_320  = 10'h140;
  localparam logic [AW-1:0] BND_384  = 10'h180;
  localparam logic [AW-1:0] BND_512  = 10'h200;
  localparam logic [AW-1:0] BND_768  = 10'h300;

  function automatic logic [3:0] addr_bits(eeap_size_t s);
    unique case (s)
      SZ_4K:   addr_bits = ABITS_4K;
      SZ_8K:   addr_bits = ABITS_8K;
      SZ_16K:  addr_bits = ABITS_16K;
      SZ_NONE: addr_bits = ABITS_16K;
    endcase
  endfunction : addr_bits

  function automatic eeap_size_t next_size(eeap_size_t s);
    unique case (s)
      SZ_16K:  next_size = SZ_4K;
      SZ_4K:   next_size = SZ_8K;
      SZ_8K:   next_size = SZ_NONE;
      SZ_NONE: next_size = SZ_NONE;
    endcase
  endfunction : next_size

  function automatic logic in_range(logic [AW-1:0] a, eeap_size_t s);
    in_range = (s != SZ_NONE) && ((a >> addr_bits(s)) == '0);
  endfunction : in_range

  function automatic logic [2:0] region_of(logic [AW-1:0] a, eeap_size_t s);
    if (a < BND_32)        region_of = 3'h0;
    else if (a < BND_64)   region_of = 3'h1;
    else if (a < BND_128)  region_of = 3'h2;
    else if (a < BND_192)  region_of = 3'h3;
    else if (s == SZ_4K)   region_of = {1'b1, a[SUB4K_LSB +: 2]};
    else if (a < BND_256)  region_of = 3'h4;
    else if (s == SZ_8K)   region_of = (a < BND_320) ? 3'h5 : (a < BND_384) ? 3'h6 : 3'h7;
    else                   region_of = (a < BND_512) ? 3'h5 : (a < BND_768) ? 3'h6 : 3'h7;
  endfunction : region_of

endpackage : eeap_pkg

// >>> verilog/eeap_top.sv
// eeprom autosize, config load and access protection behind an apb slave
// assumes ee_sck is a free-running clock from outside, sampled here at 200 MHz
// Summary of operation
// - after reset the first eeprom access is the signature read; size found by hardware
// - probe sizes in order 16 Kb, then 4 Kb, then 8 Kb
// - read signature word 0x3d under each size; match fixes size and starts load
// - signature mismatch retries with the next size in the order
// - no size matches: eeprom absent, defaults used everywhere
// - access mask is the 16-bit word 0x3f, eight 2-bit submasks
// - submask 00 read+write, 01 write only, 10 read only, 11 none
// - submasks 1:0..7:6 cover words 0-31, 32-63, 64-127, 128-191 always
// - 4 Kb: submasks 9:8..15:14 cover 16-word regions from word 192
// - 8 Kb: upper submasks cover 192-255, 256-319, 320-383, 384-511
// - 16 Kb: upper submasks cover 192-255, 256-511, 512-767, 768-1023
// - mask only loaded from the eeprom, never writable by software
// - writing the mask word needs its submask to allow writes or enable pin high
// - only cold reset loads; the host soft reset keeps the loaded image
// - signature matches only when it equals 0x5aa5
// - denied read aborts and sets read-error, not read-done
// - denied write aborts and sets write-error, not write-done
// - enable pin high skips loading and keeps defaults
//
// Design decisions made here: register access over APB and the register addresses.
module eeap_top
  import eeap_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ee_sck,
  input  wire logic        ee_miso,
  input  wire logic        nvm_load_enable_n,
  output logic             ee_cs,
  output logic             ee_mosi,
  output logic             load_done
);
  import eeap_pkg::*;

  typedef enum logic [2:0] {
    M_BOOT  = 3'h0,
    M_PROBE = 3'h1,
    M_LOAD  = 3'h3,
    M_IDLE  = 3'h2,
    M_OP    = 3'h6
  } eeap_main_t;

  typedef enum logic [2:0] {
    E_IDLE  = 3'h0,
    E_ARM   = 3'h1,
    E_SHIFT = 3'h3,
    E_GAP   = 3'h2,
    E_POLL  = 3'h6
  } eeap_eng_t;

  // ---------------- pin synchronisers
  logic sck_s1_r, sck_s2_r, sck_s3_r, miso_s1_r, miso_s2_r, en_s1_r, en_s2_r;
  logic sck_rise, sck_fall;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {sck_s1_r, sck_s2_r, sck_s3_r} <= '0;
      {miso_s1_r, miso_s2_r}         <= '0;
      {en_s1_r, en_s2_r}             <= 2'h3;
    end else if (ce) begin
      sck_s1_r  <= ee_sck;
      sck_s2_r  <= sck_s1_r;
      sck_s3_r  <= sck_s2_r;
      miso_s1_r <= ee_miso;
      miso_s2_r <= miso_s1_r;
      en_s1_r   <= nvm_load_enable_n;
      en_s2_r   <= en_s1_r;
    end
  end

  assign sck_rise = sck_s2_r & ~sck_s3_r;
  assign sck_fall = ~sck_s2_r & sck_s3_r;

  // ---------------- apb slave
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt, wr_fire, mapped;
  logic [31:0] prdata_r, prdata_nxt, rd_mux;

  // ---------------- main sequencer state
  eeap_main_t       st_r, st_nxt;
  eeap_size_t       try_r, try_nxt, size_r, size_nxt, eng_sz;
  logic             present_r, present_nxt, loaded_r, loaded_nxt, op_wr_r, op_wr_nxt;
  logic [DW-1:0]    mask_r, mask_nxt, data_r, data_nxt, eng_d;
  logic [AW-1:0]    addr_r, addr_nxt, eng_a;
  logic [MEM_AW-1:0] idx_r, idx_nxt;
  logic [1:0]       boot_r, boot_nxt;
  logic [3:0]       flags_r, flags_nxt;
  logic [6:0]       srst_r, srst_nxt;
  logic             eng_go, eng_wr, cmd_go, rd_ok, wr_ok, cfg_we;
  logic [1:0]       sub;
  logic [DW-1:0]    cfg_mem [0:(1<<MEM_AW)-1];

  // ---------------- serial engine state
  eeap_eng_t          est_r, est_nxt;
  logic [FRAME_W-1:0] sh_r, sh_nxt;
  logic [DW-1:0]      in_r, in_nxt;
  logic [CNT_W-1:0]   cnt_r, cnt_nxt, nbits_r, nbits_nxt;
  logic               ewr_r, ewr_nxt, cs_r, cs_nxt, di_r, di_nxt, done_r, done_nxt;

  always_comb begin
    mapped = 1'b1;
    rd_mux = '0;
    if (paddr[11:8] == CFG_PAGE && paddr[1:0] == 2'h0) begin
      rd_mux = {16'h0, cfg_mem[paddr[MEM_AW+1:2]]};
    end else begin
      unique case (paddr)
        OFF_ADDR:   rd_mux = {22'h0, addr_r};
        OFF_DATA:   rd_mux = {16'h0, data_r};
        OFF_CMD:    rd_mux = '0;
        OFF_STATUS: rd_mux = {23'h0, loaded_r, (st_r != M_IDLE), present_r, 2'(size_r),
                              flags_r};
        OFF_MASK:   rd_mux = {16'h0, mask_r};
        OFF_CTRL:   rd_mux = {31'h0, (srst_r != '0)};
        default:    mapped = 1'b0;
      endcase
    end
    // one wait state: pready rises in the second access cycle
    pready_nxt  = psel & penable & ~pready_r;
    pslverr_nxt = pready_nxt & ~mapped;
    prdata_nxt  = (pready_nxt && !pwrite && mapped) ? rd_mux : '0;
  end

  assign wr_fire = psel & penable & pready_r & pwrite & ~pslverr_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else if (ce) begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // permission of the current host request
  always_comb begin
    sub   = mask_r[{region_of(addr_r, size_r), 1'b0} +: 2];
    rd_ok = in_range(addr_r, size_r) && !sub[SUB_NO_RD];
    wr_ok = in_range(addr_r, size_r) &&
            (!sub[SUB_NO_WR] || (addr_r == MASK_ADDR && en_s2_r));
  end

  assign cmd_go = wr_fire && paddr == OFF_CMD && srst_r == '0 && st_r == M_IDLE &&
                  (pwdata[CMD_RD] || pwdata[CMD_WR]);

  always_comb begin
    st_nxt = st_r;  try_nxt = try_r;  size_nxt = size_r;  present_nxt = present_r;
    loaded_nxt = loaded_r;  op_wr_nxt = op_wr_r;  mask_nxt = mask_r;  data_nxt = data_r;
    addr_nxt = addr_r;  idx_nxt = idx_r;  boot_nxt = boot_r;  flags_nxt = flags_r;
    eng_go = 1'b0;  eng_wr = 1'b0;  eng_a = SIG_ADDR;  eng_d = data_r;  eng_sz = size_r;
    cfg_we = 1'b0;
    // soft reset touches only host-side state, never the loaded image
    srst_nxt = (srst_r == '0) ? '0 : srst_r - 7'h1;
    if (wr_fire && paddr == OFF_CTRL && pwdata[CTRL_SRST]) srst_nxt = SRST_CYCLES;
    if (srst_r != '0) begin
      addr_nxt  = '0;
      data_nxt  = '0;
      flags_nxt = '0;
    end else if (wr_fire && st_r == M_IDLE) begin
      if (paddr == OFF_ADDR) addr_nxt = pwdata[AW-1:0];
      if (paddr == OFF_DATA) data_nxt = pwdata[DW-1:0];
    end
    unique case (st_r)
      M_BOOT: begin
        // wait until the strap has crossed the synchroniser
        if (boot_r == BOOT_WAIT) begin
          eng_go  = 1'b1;
          eng_sz  = SZ_16K;
          try_nxt = SZ_16K;
          st_nxt  = M_PROBE;
        end else begin
          boot_nxt = boot_r + 2'h1;
        end
      end
      M_PROBE: if (done_r) begin
        if (in_r == SIG_VALUE) begin
          size_nxt    = try_r;
          present_nxt = 1'b1;
          if (en_s2_r) begin
            st_nxt     = M_IDLE;
            loaded_nxt = 1'b1;
          end else begin
            idx_nxt = '0;
            eng_go  = 1'b1;
            eng_a   = '0;
            eng_sz  = try_r;
            st_nxt  = M_LOAD;
          end
        end else if (next_size(try_r) == SZ_NONE) begin
          st_nxt     = M_IDLE;
          loaded_nxt = 1'b1;
        end else begin
          try_nxt = next_size(try_r);
          eng_sz  = next_size(try_r);
          eng_go  = 1'b1;
        end
      end
      M_LOAD: if (done_r) begin
        cfg_we = 1'b1;
        if (idx_r == MASK_ADDR[MEM_AW-1:0]) mask_nxt = in_r;
        if (idx_r == LOAD_LAST) begin
          st_nxt     = M_IDLE;
          loaded_nxt = 1'b1;
        end else begin
          idx_nxt = idx_r + 6'h1;
          eng_go  = 1'b1;
          eng_a   = AW'(idx_r + 6'h1);
        end
      end
      M_IDLE: if (cmd_go) begin
        op_wr_nxt = ~pwdata[CMD_RD];
        flags_nxt = '0;
        eng_a     = addr_r;
        eng_wr    = ~pwdata[CMD_RD];
        if (pwdata[CMD_RD] && !rd_ok) begin
          flags_nxt[FL_RD_ERR] = 1'b1;
        end else if (!pwdata[CMD_RD] && !wr_ok) begin
          flags_nxt[FL_WR_ERR] = 1'b1;
        end else begin
          eng_go = 1'b1;
          st_nxt = M_OP;
        end
      end
      M_OP: if (done_r) begin
        st_nxt = M_IDLE;
        if (op_wr_r) flags_nxt[FL_WR_DONE] = 1'b1;
        else begin
          flags_nxt[FL_RD_DONE] = 1'b1;
          data_nxt = in_r;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= M_BOOT;  try_r <= SZ_NONE;  size_r <= SZ_NONE;  present_r <= 1'b0;
      loaded_r <= 1'b0;  op_wr_r <= 1'b0;  mask_r <= MASK_DEFLT;  data_r <= '0;
      addr_r <= '0;  idx_r <= '0;  boot_r <= '0;  flags_r <= '0;  srst_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;  try_r <= try_nxt;  size_r <= size_nxt;  present_r <= present_nxt;
      loaded_r <= loaded_nxt;  op_wr_r <= op_wr_nxt;  mask_r <= mask_nxt;
      data_r <= data_nxt;  addr_r <= addr_nxt;  idx_r <= idx_nxt;  boot_r <= boot_nxt;
      flags_r <= flags_nxt;  srst_r <= srst_nxt;
    end
  end

  // image only cleared by cold reset; defaults stand where no load happened
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < (1 << MEM_AW); i++) cfg_mem[i] <= CFG_DEFLT;
    end else if (ce && cfg_we) begin
      cfg_mem[idx_r] <= in_r;
    end
  end

  // ---------------- serial engine: mosi changes on sck fall, miso taken on rise
  always_comb begin
    est_nxt = est_r;  sh_nxt = sh_r;  in_nxt = in_r;  cnt_nxt = cnt_r;
    nbits_nxt = nbits_r;  ewr_nxt = ewr_r;  cs_nxt = cs_r;  di_nxt = di_r;
    done_nxt = 1'b0;
    unique case (est_r)
      E_IDLE: if (eng_go) begin
        sh_nxt = (FRAME_W'({START_BIT, (eng_wr ? OP_WRITE : OP_READ)}) << (FRAME_W - HEAD_W))
               | (FRAME_W'(eng_a) << (DW + AW - addr_bits(eng_sz)))
               | (FRAME_W'(eng_d) << (AW - addr_bits(eng_sz)));
        nbits_nxt = CNT_W'(HEAD_W + addr_bits(eng_sz)) + CNT_W'(DW);
        ewr_nxt   = eng_wr;
        est_nxt   = E_ARM;
      end
      E_ARM: if (sck_fall) begin
        cs_nxt  = 1'b1;
        di_nxt  = sh_r[FRAME_W-1];
        sh_nxt  = sh_r << 1;
        cnt_nxt = '0;
        est_nxt = E_SHIFT;
      end
      E_SHIFT: begin
        if (sck_rise) begin
          in_nxt  = {in_r[DW-2:0], miso_s2_r};
          cnt_nxt = cnt_r + 5'h1;
        end else if (sck_fall) begin
          if (cnt_r == nbits_r) begin
            cs_nxt   = 1'b0;
            di_nxt   = 1'b0;
            est_nxt  = ewr_r ? E_GAP : E_IDLE;
            done_nxt = ~ewr_r;
          end else begin
            di_nxt = sh_r[FRAME_W-1];
            sh_nxt = sh_r << 1;
          end
        end
      end
      // one sck period of chip deselect, then poll ready on miso
      E_GAP: if (sck_fall) begin
        cs_nxt  = 1'b1;
        est_nxt = E_POLL;
      end
      E_POLL: if (sck_rise && miso_s2_r) begin
        cs_nxt   = 1'b0;
        done_nxt = 1'b1;
        est_nxt  = E_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      est_r <= E_IDLE;  sh_r <= '0;  in_r <= '0;  cnt_r <= '0;  nbits_r <= '0;
      ewr_r <= 1'b0;  cs_r <= 1'b0;  di_r <= 1'b0;  done_r <= 1'b0;
    end else if (ce) begin
      est_r <= est_nxt;  sh_r <= sh_nxt;  in_r <= in_nxt;  cnt_r <= cnt_nxt;
      nbits_r <= nbits_nxt;  ewr_r <= ewr_nxt;  cs_r <= cs_nxt;  di_r <= di_nxt;
      done_r <= done_nxt;
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign ee_cs     = cs_r;
  assign ee_mosi   = di_r;
  assign load_done = loaded_r;

  // ---------------- checks
  AST_FIRST_PROBE: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && st_r == M_BOOT && boot_r == BOOT_WAIT) |=>
      (st_r == M_PROBE && try_r == SZ_16K && est_r == E_ARM && nbits_r == 5'd29))
    else $error("first probe is not a 16 Kb signature read");
  AST_PROBE_ORDER: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && st_r == M_PROBE && done_r && in_r != SIG_VALUE && try_r == SZ_16K) |=>
      (try_r == SZ_4K && st_r == M_PROBE && nbits_r == 5'd27))
    else $error("probe after 16 Kb is not 4 Kb");
  AST_RETRY_8K: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && st_r == M_PROBE && done_r && in_r != SIG_VALUE && try_r == SZ_4K) |=>
      (try_r == SZ_8K && est_r == E_ARM))
    else $error("no retry with 8 Kb after 4 Kb mismatch");
  AST_SIG_HIT: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && st_r == M_PROBE && done_r && in_r == SIG_VALUE) |=>
      (present_r && size_r == $past(try_r)))
    else $error("signature match did not fix the size");
  AST_NO_SIG: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && st_r == M_PROBE && done_r && in_r != SIG_VALUE && try_r == SZ_8K) |=>
      (st_r == M_IDLE && size_r == SZ_NONE && !present_r && mask_r == MASK_DEFLT))
    else $error("absent eeprom not handled with defaults");
  AST_MASK_LOAD_ONLY: assert property (@(posedge clk) disable iff (!reset_n)
    (mask_r != $past(mask_r)) |->
      ($past(st_r) == M_LOAD && $past(idx_r) == MASK_ADDR[MEM_AW-1:0]))
    else $error("mask changed outside the load of word 0x3f");
  AST_RD_DENY: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_go && pwdata[CMD_RD] && !rd_ok) |=>
      (flags_r == 4'h2 && st_r == M_IDLE && est_r == E_IDLE && !cs_r))
    else $error("denied read was not aborted with read error");
  AST_WR_DENY: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_go && !pwdata[CMD_RD] && !wr_ok) |=>
      (flags_r == 4'h8 && st_r == M_IDLE && est_r == E_IDLE))
    else $error("denied write was not aborted with write error");
  AST_MASK_OVERRIDE: assert property (@(posedge clk) disable iff (!reset_n)
    (cmd_go && !pwdata[CMD_RD] && addr_r == MASK_ADDR && size_r != SZ_NONE && en_s2_r)
      |=> (st_r == M_OP && !flags_r[FL_WR_ERR]))
    else $error("mask write refused while enable pin high");
  AST_STRAP_SKIP: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && st_r == M_PROBE && done_r && in_r == SIG_VALUE && en_s2_r) |=>
      (st_r == M_IDLE && loaded_r && mask_r == MASK_DEFLT))
    else $error("load not skipped with enable pin high");
  AST_SOFT_KEEP: assert property (@(posedge clk) disable iff (!reset_n)
    (srst_r != '0 && st_r inside {M_IDLE, M_OP}) |=>
      (st_r inside {M_IDLE, M_OP} && mask_r == $past(mask_r) && loaded_r))
    else $error("soft reset disturbed the loaded image");

endmodule : eeap_top

// >>> tb/eeap_eeprom_model.sv
// word-wide serial eeprom model, microwire-like, for the eeap bench
// assumes sck runs free; mosi taken at sck rise, miso moved after sck fall
module eeap_eeprom_model #(
  parameter int          ABITS = 9,
  parameter logic [15:0] MASK  = 16'h0000
) (
  input  wire logic sck,
  input  wire logic cs,
  input  wire logic mosi,
  input  wire logic present,
  output logic      miso
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HEAD = 3 + ABITS;
  logic [15:0] mem [1024];
  logic [31:0] sh = '0;
  logic [9:0]  addr = '0;
  logic [1:0]  op = '0;
  int          n = 0;
  int          busy = 0;
  int          flen [$];
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 16'h1000 + 16'(i);
    end
    mem[10'h03d] = 16'h5aa5;
    mem[10'h03f] = MASK;
    miso = 1'b0;
  end
  always @(posedge sck) begin
    if (busy > 0) begin
      busy--;
    end
    if (cs && (n > 0 || mosi)) begin
      sh = {sh[30:0], mosi};
      n++;
      if (n == HEAD) begin
        addr = 10'(sh[ABITS-1:0]);
        op = sh[ABITS+1:ABITS];
      end
      if (n == HEAD + 16 && op == 2'h1) begin
        mem[addr] = sh[15:0];
        busy = 20;
      end
    end
  end
  always @(negedge sck) begin
    if (cs && present && op == 2'h2 && n >= HEAD && n < HEAD + 16) begin
      miso <= mem[addr][15 - (n - HEAD)];
    end else if (cs && n == 0) begin
      miso <= (busy == 0);
    end else begin
      // released line: never keeps the last bit
      miso <= ~miso;
    end
  end
  // ready status shows as soon as the part is selected, not at the next sck fall
  always @(posedge cs) begin
    if (n == 0) begin
      miso <= (busy == 0);
    end
  end
  always @(negedge cs) begin
    if (n > 0) begin
      flen.push_back(n);
    end
    n = 0;
  end
endmodule : eeap_eeprom_model

// >>> tb/tb_top.sv
// self-checking bench for eeap_top: probing, load, protection, resets
// assumes an 8 Kb eeprom model on a free-running 64 ns link clock
module tb_top
  import eeap_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic        wr;
    logic [9:0]  a;
    logic [15:0] d;
    logic [3:0]  fl;
  } eeap_row_t;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        ee_sck = 1'b0;
  logic        ee_cs;
  logic        ee_mosi;
  logic        ee_miso;
  logic        load_done;
  logic        pin_n = 1'b0;
  logic        present = 1'b1;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          f0 = 0;
  eeap_row_t   rows [16] = '{
    '{1'b0, 10'h01f, 16'h101f, 4'h1}, '{1'b0, 10'h020, 16'h1020, 4'h1},
    '{1'b0, 10'h040, 16'h0000, 4'h2}, '{1'b0, 10'h0bf, 16'h0000, 4'h2},
    '{1'b0, 10'h0ff, 16'h10ff, 4'h1}, '{1'b0, 10'h13f, 16'h113f, 4'h1},
    '{1'b0, 10'h140, 16'h0000, 4'h2}, '{1'b0, 10'h1ff, 16'h0000, 4'h2},
    '{1'b0, 10'h200, 16'h0000, 4'h2}, '{1'b1, 10'h03f, 16'h0000, 4'h8},
    '{1'b1, 10'h07f, 16'h0a0a, 4'h4}, '{1'b1, 10'h180, 16'h0000, 4'h8},
    '{1'b1, 10'h17f, 16'h0b0b, 4'h4}, '{1'b1, 10'h100, 16'h0000, 4'h8},
    '{1'b1, 10'h000, 16'hbeef, 4'h4}, '{1'b0, 10'h000, 16'hbeef, 4'h1}};
  always #2.5 clk = ~clk;
  initial #1.7 forever #32 ee_sck = ~ee_sck;
  eeap_top u_eeap_top (
    .clk(clk), .reset_n(reset_n), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ee_sck(ee_sck), .ee_miso(ee_miso), .nvm_load_enable_n(pin_n),
    .ee_cs(ee_cs), .ee_mosi(ee_mosi), .load_done(load_done));
  // mask denies writes to its own region, as on a production board
  eeap_eeprom_model #(.ABITS(9), .MASK(16'hd8d8)) u_eeap_eeprom_model (
    .sck(ee_sck), .cs(ee_cs), .mosi(ee_mosi), .present(present), .miso(ee_miso));
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    check("pready", 1, pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check("register", e, rd);
  endtask : rchk
  task automatic cmd(input logic wr, input logic [9:0] a, input logic [15:0] d);
    int k;
    apb(1'b1, OFF_ADDR, 32'(a));
    if (wr) apb(1'b1, OFF_DATA, 32'(d));
    apb(1'b1, OFF_CMD, wr ? 32'h2 : 32'h1);
    k = 0;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0);
      k++;
    end while (rd[3:0] === 4'h0 && k < 2000);
  endtask : cmd
  task automatic cold(input logic pin, input logic pres);
    pin_n <= pin;
    present <= pres;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    f0 = u_eeap_eeprom_model.flen.size();
    for (int k = 0; k < 40000 && load_done !== 1'b1; k++) @(posedge clk);
    check("load_done", 1, load_done);
  endtask : cold
  task automatic finish_test();
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    #400000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    @(posedge clk);
    cold(1'b0, 1'b1);
    check("probe 16k", 29, u_eeap_eeprom_model.flen[0]);
    check("probe 4k", 27, u_eeap_eeprom_model.flen[1]);
    check("probe 8k", 28, u_eeap_eeprom_model.flen[2]);
    check("frames", 67, u_eeap_eeprom_model.flen.size());
    rchk(OFF_STATUS, 32'h160);
    rchk(12'h100, 32'h1000);
    rchk(12'h1f4, 32'h5aa5);
    apb(1'b1, OFF_MASK, 32'h0);
    rchk(OFF_MASK, 32'hd8d8);
    apb(1'b0, 12'h020, 32'h0);
    check("slverr", 1, err);
    foreach (rows[i]) begin
      f0 = u_eeap_eeprom_model.flen.size();
      cmd(rows[i].wr, rows[i].a, rows[i].d);
      check("status", 32'h160 | 32'(rows[i].fl), rd & 32'h1ff);
      if (rows[i].fl == 4'h1) rchk(OFF_DATA, 32'(rows[i].d));
      if (rows[i].fl[3] | rows[i].fl[1])
        check("frames", f0, u_eeap_eeprom_model.flen.size());
    end
    // pin high lets the mask word be rewritten although its submask denies it
    pin_n <= 1'b1;
    cmd(1'b1, MASK_ADDR, 16'hd8d8);
    check("status", 32'h164, rd & 32'h1ff);
    rchk(OFF_MASK, 32'hd8d8);
    pin_n <= 1'b0;
    f0 = u_eeap_eeprom_model.flen.size();
    apb(1'b1, OFF_CTRL, 32'h1);
    rchk(OFF_CTRL, 32'h1);
    repeat (80) @(posedge clk);
    rchk(OFF_CTRL, 32'h0);
    rchk(12'h100, 32'h1000);
    rchk(OFF_STATUS, 32'h160);
    check("frames", f0, u_eeap_eeprom_model.flen.size());
    cold(1'b1, 1'b1);
    check("frames", f0 + 3, u_eeap_eeprom_model.flen.size());
    rchk(12'h100, 32'h0);
    cmd(1'b1, 10'h03f, 16'h00f0);
    check("status", 32'h4, rd & 32'hf);
    cold(1'b0, 1'b0);
    check("frames", f0 + 3, u_eeap_eeprom_model.flen.size());
    rchk(OFF_STATUS, 32'h100);
    rchk(12'h100, 32'h0);
    cmd(1'b0, 10'h000, 16'h0);
    check("status", 32'h102, rd & 32'h1ff);
    finish_test();
  end
endmodule : tb_top
